// >>> rtl/adc_result_offset_regs.sv
// Result, ready-flag and offset-coefficient registers of the dual converter.
//
// Implementation choice: register access over AXI4-Lite.

////////////////////////////////////////////////////////////////////////////////

// Operation
// R1: Current result register is read-only, showing the 16-bit current result.
// R2: No new current result is stored while current ready flag is set.
// R3: Reading the current result clears ready flags 2..0 and flag 5.
// R4: Voltage/temperature result register is read-only, 16-bit shared result.
// R5: No voltage/temperature store while voltage or temperature flag is set.
// R6: If current converter idle, its read clears flags 2..1 and 5.
// R7: Current offset coefficient is a 16-bit read/write register.
// R8: Offset registers load factory values at power-on, not a constant.
// R9: Software may copy the calibrated current result into its offset.
// R10: Voltage offset coefficient is a 16-bit read/write register.
// R11: Software may copy the calibrated voltage result into its offset.
// R12: Each channel's offset is applied to raw data before storing.
module adc_result_offset_regs
  import adc_regs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire conv_sample_t cur_sample,
  input wire conv_sample_t vt_sample,
  input wire logic cur_converter_active,
  input wire logic aux_ready_evt,
  input wire logic [RES_W-1:0] factory_cur_offset,
  input wire logic [RES_W-1:0] factory_volt_offset,
  output logic [FLAG_W-1:0] ready_flags
);

  //////////////////////////////////////////////////////////////////////////////
  // Bus front end.

  reg_wr_t wr;
  reg_rd_t rd;
  logic wr_hit;
  logic rd_hit;
  logic [DATA_W-1:0] rd_data;

  axil_slave_port u_port (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr(wr),
    .wr_hit(wr_hit),
    .rd(rd),
    .rd_hit(rd_hit),
    .rd_data(rd_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Address decode.

  logic rd_cur_res;
  logic rd_vt_res;
  logic wr_cur_off;
  logic wr_volt_off;
  logic wr_lost;

  // One table serves both directions, so a word can never answer a read
  // with OKAY while a write to it is refused, or the other way round.
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr)
      CUR_RESULT_ADDR: begin
        hit = 1'b1;
      end
      VT_RESULT_ADDR: begin
        hit = 1'b1;
      end
      STATUS_ADDR: begin
        hit = 1'b1;
      end
      LOST_ADDR: begin
        hit = 1'b1;
      end
      CUR_OFFSET_ADDR: begin
        hit = 1'b1;
      end
      VOLT_OFFSET_ADDR: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction : addr_mapped

  // Protection bits carry no meaning here; every access is treated alike.
  always_comb begin
    rd_cur_res = rd.en && (rd.addr == CUR_RESULT_ADDR);
    rd_vt_res = rd.en && (rd.addr == VT_RESULT_ADDR);
    wr_cur_off = wr.en && (wr.addr == CUR_OFFSET_ADDR);
    wr_volt_off = wr.en && (wr.addr == VOLT_OFFSET_ADDR);
    wr_lost = wr.en && (wr.addr == LOST_ADDR);
    // Writes to the read-only words are accepted and dropped.
    wr_hit = addr_mapped(wr.addr);
    rd_hit = addr_mapped(rd.addr);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Offset coefficients.

  logic [RES_W-1:0] cur_off_r;
  logic [RES_W-1:0] cur_off_nxt;
  logic [RES_W-1:0] volt_off_r;
  logic [RES_W-1:0] volt_off_nxt;
  logic factory_load_r;
  logic factory_load_nxt;

  // Only byte lanes 0 and 1 carry coefficient bits; strobes for the upper
  // lanes have nothing to land on and are ignored.
  function automatic logic [RES_W-1:0] merge16(
    input logic [RES_W-1:0] old_val,
    input logic [DATA_W-1:0] data,
    input logic [3:0] strb
  );
    logic [RES_W-1:0] res;
    res = old_val;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge16

  // The factory values are taken in the first cycle after reset release,
  // so a strap that settles during reset is still caught correctly.
  always_comb begin
    factory_load_nxt = 1'b0;
    cur_off_nxt = cur_off_r;
    volt_off_nxt = volt_off_r;
    if (factory_load_r) begin
      cur_off_nxt = factory_cur_offset; // [R8]
      volt_off_nxt = factory_volt_offset; // [R8]
    end else begin
      if (wr_cur_off) begin
        cur_off_nxt = merge16(cur_off_r, wr.data, wr.strb); // [R7] [R9]
      end
      if (wr_volt_off) begin
        volt_off_nxt = merge16(volt_off_r, wr.data, wr.strb); // [R10] [R11]
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      factory_load_r <= 1'b1;
      cur_off_r <= OFFSET_RST;
      volt_off_r <= OFFSET_RST;
    end else begin
      factory_load_r <= factory_load_nxt;
      cur_off_r <= cur_off_nxt;
      volt_off_r <= volt_off_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result capture and ready flags.

  logic [RES_W-1:0] cur_res_r;
  logic [RES_W-1:0] cur_res_nxt;
  logic [RES_W-1:0] vt_res_r;
  logic [RES_W-1:0] vt_res_nxt;
  // Bits 3 and 4 have no source and always read back as zero.
  logic [FLAG_W-1:0] flags_r;
  logic [FLAG_W-1:0] flags_nxt;
  logic [FLAG_W-1:0] clr_mask;
  logic [FLAG_W-1:0] set_mask;
  logic cur_store;
  logic vt_store;
  logic cur_drop;
  logic vt_drop;

  always_comb begin
    clr_mask = '0;
    set_mask = '0;
    if (rd_cur_res) begin
      clr_mask[CUR_RDY_BIT] = 1'b1; // [R3]
      clr_mask[VOLT_RDY_BIT] = 1'b1; // [R3]
      clr_mask[TEMP_RDY_BIT] = 1'b1; // [R3]
      clr_mask[AUX_RDY_BIT] = 1'b1; // [R3]
    end
    // While the current converter runs, its own result read does the clearing.
    if (rd_vt_res && !cur_converter_active) begin
      clr_mask[VOLT_RDY_BIT] = 1'b1; // [R6]
      clr_mask[TEMP_RDY_BIT] = 1'b1; // [R6]
      clr_mask[AUX_RDY_BIT] = 1'b1; // [R6]
    end
    // A held result is never overwritten: the new sample is discarded.
    cur_store = cur_sample.valid && !flags_r[CUR_RDY_BIT]; // [R2]
    vt_store = vt_sample.valid && !flags_r[VOLT_RDY_BIT] &&
               !flags_r[TEMP_RDY_BIT]; // [R5]
    // A sample refused by a held flag counts as lost, so software can tell
    // a stale result from a converter that has gone quiet.
    cur_drop = cur_sample.valid && !cur_store;
    vt_drop = vt_sample.valid && !vt_store;
    if (cur_store) begin
      set_mask[CUR_RDY_BIT] = 1'b1;
    end
    if (vt_store) begin
      set_mask[VOLT_RDY_BIT] = !vt_sample.sel_temp;
      set_mask[TEMP_RDY_BIT] = vt_sample.sel_temp;
    end
    set_mask[AUX_RDY_BIT] = aux_ready_evt;
    // A flag raised in the same cycle as a clearing read stays set.
    flags_nxt = (flags_r & ~clr_mask) | set_mask;
    cur_res_nxt = cur_res_r;
    vt_res_nxt = vt_res_r;
    if (cur_store) begin
      cur_res_nxt = cur_sample.data - cur_off_r; // [R1] [R12]
    end
    if (vt_store) begin
      // Temperature offset lives elsewhere; only voltage is corrected here.
      vt_res_nxt = vt_sample.sel_temp ? vt_sample.data
                   : vt_sample.data - volt_off_r; // [R4] [R12]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cur_res_r <= RESULT_RST;
      vt_res_r <= RESULT_RST;
      flags_r <= FLAGS_RST;
    end else begin
      cur_res_r <= cur_res_nxt;
      vt_res_r <= vt_res_nxt;
      flags_r <= flags_nxt;
    end
  end

  assign ready_flags = flags_r;

  //////////////////////////////////////////////////////////////////////////////
  // Lost-sample counters.

  logic [CNT_W-1:0] lost_cur_r;
  logic [CNT_W-1:0] lost_cur_nxt;
  logic [CNT_W-1:0] lost_vt_r;
  logic [CNT_W-1:0] lost_vt_nxt;

  // Counters saturate so a long unattended run never wraps back to a small
  // and misleading figure; any write to the word clears both.
  always_comb begin
    lost_cur_nxt = lost_cur_r;
    lost_vt_nxt = lost_vt_r;
    if (wr_lost) begin
      lost_cur_nxt = LOST_RST;
      lost_vt_nxt = LOST_RST;
    end else begin
      if (cur_drop && (lost_cur_r != '1)) begin
        lost_cur_nxt = lost_cur_r + 8'h01;
      end
      if (vt_drop && (lost_vt_r != '1)) begin
        lost_vt_nxt = lost_vt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      lost_cur_r <= LOST_RST;
      lost_vt_r <= LOST_RST;
    end else begin
      lost_cur_r <= lost_cur_nxt;
      lost_vt_r <= lost_vt_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data.

  always_comb begin
    rd_data = '0;
    // Bits above each field read as zero for every word.
    case (rd.addr)
      CUR_RESULT_ADDR: begin
        rd_data[RES_W-1:0] = cur_res_r; // [R1]
      end
      VT_RESULT_ADDR: begin
        rd_data[RES_W-1:0] = vt_res_r; // [R4]
      end
      // The activity bit is read live, so software sees whether a read of
      // the v/t result would clear the flags right now.
      STATUS_ADDR: begin
        rd_data[FLAG_W-1:0] = flags_r;
        rd_data[CUR_ACT_BIT] = cur_converter_active;
      end
      LOST_ADDR: begin
        rd_data[LOST_CUR_LSB +: CNT_W] = lost_cur_r;
        rd_data[LOST_VT_LSB +: CNT_W] = lost_vt_r;
      end
      CUR_OFFSET_ADDR: begin
        rd_data[RES_W-1:0] = cur_off_r; // [R7]
      end
      VOLT_OFFSET_ADDR: begin
        rd_data[RES_W-1:0] = volt_off_r; // [R10]
      end
      default: begin
        rd_data = '0;
      end
    endcase
  end

endmodule : adc_result_offset_regs

// >>> rtl/adc_regs_pkg.sv
// Shared constants and carrier types of the converter result/offset block.
package adc_regs_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int RES_W = 16;
  localparam int CNT_W = 8;

  // Register byte addresses.
  localparam logic [31:0] CUR_RESULT_ADDR = 32'hffff0520;
  localparam logic [31:0] VT_RESULT_ADDR = 32'hffff0524;
  localparam logic [31:0] STATUS_ADDR = 32'hffff0528;
  localparam logic [31:0] LOST_ADDR = 32'hffff052c;
  localparam logic [31:0] CUR_OFFSET_ADDR = 32'hffff0530;
  localparam logic [31:0] VOLT_OFFSET_ADDR = 32'hffff0534;

  // Status field positions.
  localparam int CUR_RDY_BIT = 0;
  localparam int VOLT_RDY_BIT = 1;
  localparam int TEMP_RDY_BIT = 2;
  localparam int AUX_RDY_BIT = 5;
  localparam int CUR_ACT_BIT = 8;
  localparam int FLAG_W = 6;

  // Lost-sample counter field positions.
  localparam int LOST_CUR_LSB = 0;
  localparam int LOST_VT_LSB = 8;

  // Reset values.
  localparam logic [RES_W-1:0] RESULT_RST = 16'h0000;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 6'h00;
  localparam logic [CNT_W-1:0] LOST_RST = 8'h00;
  localparam logic [RES_W-1:0] OFFSET_RST = 16'h0000;

  // AXI4-Lite responses.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [3:0] strb;
  } reg_wr_t;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
  } reg_rd_t;

  typedef struct packed {
    logic valid;
    logic sel_temp;
    logic [RES_W-1:0] data;
  } conv_sample_t;

endpackage : adc_regs_pkg

// >>> rtl/axil_slave_port.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes.
module axil_slave_port
  import adc_regs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output reg_wr_t wr,
  input wire logic wr_hit,
  output reg_rd_t rd,
  input wire logic rd_hit,
  input wire logic [DATA_W-1:0] rd_data
);

  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt, ar_addr_r, ar_addr_nxt;
  logic [DATA_W-1:0] w_data_r, w_data_nxt, rdata_r, rdata_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt, ar_held_r, ar_held_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic arready_r, arready_nxt;

  // Strobes come from registered state only, so each lasts one cycle.
  assign wr = '{en: aw_held_r & w_held_r & ~bvalid_r, addr: aw_addr_r,
                data: w_data_r, strb: w_strb_r};
  assign rd = '{en: ar_held_r, addr: ar_addr_r};

  always_comb begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt = w_held_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (s_axi_awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_held_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (wr.en) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    awready_nxt = ~aw_held_nxt & ~bvalid_nxt;
    wready_nxt = ~w_held_nxt & ~bvalid_nxt;
    ar_held_nxt = 1'b0;
    ar_addr_nxt = ar_addr_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && arready_r) begin
      ar_held_nxt = 1'b1;
      ar_addr_nxt = s_axi_araddr;
    end
    if (ar_held_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_hit ? rd_data : '0;
      rresp_nxt = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    arready_nxt = ~ar_held_nxt & ~rvalid_nxt & ~ar_held_r;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      ar_held_r <= 1'b0;
      ar_addr_r <= '0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
    end else begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r <= w_held_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      ar_held_r <= ar_held_nxt;
      ar_addr_r <= ar_addr_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      arready_r <= arready_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule : axil_slave_port

// >>> verif/adc_result_offset_regs_asserts.sv
// Concurrent checks on ready flags and read timing of the register block.
module adc_result_offset_regs_asserts
  import adc_regs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire conv_sample_t cur_sample,
  input wire conv_sample_t vt_sample,
  input wire logic cur_converter_active,
  input wire logic aux_ready_evt,
  input wire logic [FLAG_W-1:0] ready_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic cur_rd;
  logic vt_rd;
  logic quiet;
  assign cur_rd = s_axi_arvalid && s_axi_arready
                  && s_axi_araddr == CUR_RESULT_ADDR;
  assign vt_rd = s_axi_arvalid && s_axi_arready
                 && s_axi_araddr == VT_RESULT_ADDR;
  // A new event in the clearing edge wins, so clears are checked when quiet.
  assign quiet = !cur_sample.valid && !vt_sample.valid && !aux_ready_evt;
  ////////////////////////////////////////////////////////////////////////////
  AST_CUR_SET: assert property (cur_sample.valid && !ready_flags[0]
    |=> ready_flags[0]) else $error("current ready flag not set by sample");
  AST_VOLT_SET: assert property (vt_sample.valid && !vt_sample.sel_temp
    && ready_flags[2:1] == 2'b00 |=> ready_flags[VOLT_RDY_BIT])
    else $error("voltage flag not set");
  AST_TEMP_SET: assert property (vt_sample.valid && vt_sample.sel_temp
    && ready_flags[2:1] == 2'b00 |=> ready_flags[TEMP_RDY_BIT])
    else $error("temperature flag not set");
  AST_CUR_CLR: assert property (cur_rd ##1 quiet
    |=> ready_flags == 6'h00)
    else $error("current result read left flags set");
  AST_VT_CLR: assert property (vt_rd ##1 (quiet &&
    !cur_converter_active) |=> ready_flags[2:1] == 2'b00
    && !ready_flags[AUX_RDY_BIT]) else $error("idle v/t read left flags set");
  AST_VT_KEEP: assert property (vt_rd ##1 (quiet &&
    cur_converter_active) |=> ready_flags == $past(ready_flags))
    else $error("v/t read cleared flags while current converter ran");
  AST_FLAG_HOLD: assert property (ready_flags[0] && !cur_rd
    && !$past(cur_rd) |=> ready_flags[0])
    else $error("current flag dropped without a result read");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready
    |-> ##2 s_axi_rvalid) else $error("read answer late");
  cover property (cur_rd ##1 quiet);
  cover property (vt_rd && cur_converter_active);
  cover property (cur_sample.valid && ready_flags[0]);
endmodule : adc_result_offset_regs_asserts

bind adc_result_offset_regs adc_result_offset_regs_asserts chk_u (
  .sys_clk(sys_clk), .resetn(resetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .cur_sample(cur_sample),
  .vt_sample(vt_sample), .cur_converter_active(cur_converter_active),
  .aux_ready_evt(aux_ready_evt), .ready_flags(ready_flags));

// >>> verif/testbench.sv
// Self-checking bench for the converter result and offset registers.
module testbench
  import adc_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  conv_sample_t cur_sample = '0, vt_sample = '0;
  logic cur_converter_active = 1'b0, aux_ready_evt = 1'b0;
  logic [15:0] fac_cur = 16'h0010, fac_volt = 16'h1220;
  logic [FLAG_W-1:0] ready_flags;
  int errors = 0, checked = 0;
  logic [31:0] d;
  logic [1:0] r;

  always #4 sys_clk = ~sys_clk;

  adc_result_offset_regs dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1),
    .cur_sample(cur_sample), .vt_sample(vt_sample),
    .cur_converter_active(cur_converter_active),
    .aux_ready_evt(aux_ready_evt), .factory_cur_offset(fac_cur),
    .factory_volt_offset(fac_volt), .ready_flags(ready_flags));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // Each channel is released at the rising edge that takes it; only the
  // watchdog ends a wait.
  task automatic wr(input logic [31:0] a, dat, input logic [3:0] s,
                    output logic [1:0] resp);
    logic pa, pw;
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(posedge sys_clk);
      if (pa && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] dat,
                    output logic [1:0] resp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    dat = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : rd

  task automatic rdchk(input logic [31:0] a, exp);
    logic [31:0] v;
    logic [1:0] rr;
    rd(a, v, rr);
    check("rdata", v, exp);
  endtask : rdchk

  // Kind 0 current, 1 voltage, 2 temperature, 3 auxiliary ready event.
  task automatic ev(input int k, input logic [15:0] raw);
    cur_sample <= {k == 0, 1'b0, raw};
    vt_sample <= {k == 1 || k == 2, k == 2, raw};
    aux_ready_evt <= k == 3;
    @(posedge sys_clk);
    cur_sample <= '0;
    vt_sample <= '0;
    aux_ready_evt <= 1'b0;
    @(posedge sys_clk);
  endtask : ev

  // Offset calibration as software does it: copy the result into the offset.
  task automatic cal(input int k, input logic [31:0] ra, oa,
                     input logic [15:0] raw, off);
    logic [31:0] v;
    logic [1:0] rr;
    ev(k, raw);
    rd(ra, v, rr);
    check("result", v, {16'h0, raw - off});
    wr(oa, v, 4'hf, rr);
    rdchk(oa, v);
    ev(k, raw);
    rdchk(ra, {16'h0, raw - v[15:0]});
  endtask : cal

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    rdchk(CUR_OFFSET_ADDR, 32'h00000010);
    rdchk(VOLT_OFFSET_ADDR, 32'h00001220);
    for (int i = 0; i < 2; i++) begin
      d = i ? VT_RESULT_ADDR : CUR_RESULT_ADDR;
      rdchk(d, 32'h0);
      wr(d, 32'h00005a5a, 4'hf, r);
      check("bresp", 32'(r), 32'(RESP_OKAY));
      rdchk(d, 32'h0);
    end
    wr(32'hffff0550, 32'h1, 4'hf, r);
    check("bresp", 32'(r), 32'(RESP_SLVERR));
    rd(32'hffff0550, d, r);
    check("rresp", 32'(r), 32'(RESP_SLVERR));
    wr(CUR_OFFSET_ADDR, 32'habcd0005, 4'hf, r);
    rdchk(CUR_OFFSET_ADDR, 32'h00000005);
    wr(VOLT_OFFSET_ADDR, 32'h0000ff07, 4'h1, r);
    rdchk(VOLT_OFFSET_ADDR, 32'h00001207);
    ev(0, 16'h0105);
    check("flags", 32'(ready_flags), 32'h01);
    ev(0, 16'h0999);
    rdchk(CUR_RESULT_ADDR, 32'h00000100);
    check("flags", 32'(ready_flags), 32'h00);
    ev(1, 16'h1407);
    ev(3, 16'h0);
    ev(0, 16'h0006);
    ev(2, 16'h0777);
    check("flags", 32'(ready_flags), 32'h23);
    rdchk(CUR_RESULT_ADDR, 32'h00000001);
    check("flags", 32'(ready_flags), 32'h00);
    rdchk(VT_RESULT_ADDR, 32'h00000200);
    ev(2, 16'h0333);
    ev(3, 16'h0);
    cur_converter_active <= 1'b1;
    rdchk(VT_RESULT_ADDR, 32'h00000333);
    check("flags", 32'(ready_flags), 32'h24);
    rdchk(STATUS_ADDR, 32'h00000124);
    cur_converter_active <= 1'b0;
    rdchk(VT_RESULT_ADDR, 32'h00000333);
    check("flags", 32'(ready_flags), 32'h00);
    cal(0, CUR_RESULT_ADDR, CUR_OFFSET_ADDR, 16'h0050, 16'h0005);
    cal(1, VT_RESULT_ADDR, VOLT_OFFSET_ADDR, 16'h1300, 16'h1207);
    rdchk(LOST_ADDR, 32'h00000101);
    // A second power-on with new strap values must reload both offsets.
    ev(0, 16'h0050);
    fac_cur <= 16'h0123;
    fac_volt <= 16'h0456;
    resetn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    rdchk(CUR_OFFSET_ADDR, 32'h00000123);
    rdchk(VOLT_OFFSET_ADDR, 32'h00000456);
    rdchk(CUR_RESULT_ADDR, 32'h0);
    tally_and_finish();
  end

  // The whole sequence needs well under two thousand cycles.
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    tally_and_finish();
  end
endmodule : testbench
